// ### hdl/eep_slave.sv
`timescale 1ns/10ps
module eep_slave #(
  parameter int WRITE_CYCLES = eep_pkg::EEP_WRITE_CYCLES,
  parameter int ADDR_W       = eep_pkg::EEP_ADDR_W,
  parameter int PAGE_W       = eep_pkg::EEP_PAGE_W
) (
  input  wire logic                    clk_in,
  input  wire logic                    reset_in,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_out,
  input  wire eep_pkg::eep_strap_type  strap_in,
  input  wire logic                    wp_in,
  output eep_pkg::eep_status_type      status_out
);
  import eep_pkg::*;

  localparam int              DEPTH    = 1 << ADDR_W;
  localparam int              PAGE_N   = 1 << PAGE_W;
  localparam int              HI_W     = ADDR_W - EEP_BYTE_W;
  localparam int              CNT_W    = $clog2(WRITE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);

  eep_pins_type              pins_raw;
  eep_pins_type              pins_s;
  logic                      scl_s;
  logic                      sda_s;
  logic                      wp_s;
  eep_strap_type             strap_s;
  logic                      scl_prev_q;
  logic                      sda_prev_q;
  eep_phase_type             phase_q;
  eep_phase_type             phase_nx;
  logic [3:0]                bit_cnt_q;
  logic [EEP_BYTE_W-1:0]     shift_q;
  logic [EEP_BYTE_W-1:0]     tx_q;
  logic                      sda_oe_q;
  logic                      m_ack_q;
  logic [ADDR_W-1:0]         addr_q;
  logic [ADDR_W-1:0]         addr_next;
  logic [ADDR_W-1:0]         page_next;
  logic [EEP_BYTE_W-1:0]     page_buf_q [PAGE_N];
  logic [PAGE_N-1:0]         page_vld_q;
  logic                      busy_q;
  logic [CNT_W-1:0]          busy_cnt_q;
  logic [PAGE_W:0]           commit_q;
  logic [EEP_BYTE_W-1:0]     mem_q [DEPTH];
  logic [EEP_BYTE_W-1:0]     rd_byte;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_det;
  logic                      stop_det;
  logic                      bits_done;
  logic                      ack_done;
  logic                      active;
  logic                      type_hit;
  logic                      sel_hit;
  logic                      slave_hit;
  logic                      dir_read;
  logic                      bit_in;
  logic                      byte_end;
  logic                      slot_end;
  logic                      tx_step;
  logic                      load_rd;
  logic                      accept;
  logic                      wr_byte;
  logic                      write_go;
  logic                      busy_end;
  logic                      commit_en;
  logic [PAGE_W-1:0]         commit_idx;
  logic [PAGE_W-1:0]         page_idx;

  // Pins cross into the clock domain together
  assign pins_raw = {scl_in, sda_in, wp_in, strap_in};

  eep_sync2 #(
    .W ($bits(eep_pins_type))
  ) u_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .d_in     (pins_raw),
    .q_out    (pins_s)
  );

  assign scl_s   = pins_s.scl;
  assign sda_s   = pins_s.sda;
  assign wp_s    = pins_s.wp;
  // Floating straps need a board pull-down; logic sees zero then
  assign strap_s = pins_s.strap;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      scl_prev_q <= 1'b0;
      sda_prev_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Edge and condition decode
  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign bits_done = (bit_cnt_q == EEP_BYTE_CNT);
  assign ack_done  = (bit_cnt_q == EEP_ACK_CNT);
  // Idle and skip phases ignore the bus until a Start
  assign active    = (phase_q != PH_IDLE) && (phase_q != PH_SKIP);

  // Slave address compare
  assign type_hit  = (shift_q[EEP_TYPE_MSB:EEP_TYPE_LSB] == EEP_TYPE_CODE);
  assign sel_hit   = (shift_q[EEP_SEL_MSB:EEP_SEL_LSB] == strap_s);
  assign slave_hit = type_hit & sel_hit & ~busy_q;
  assign dir_read  = (shift_q[EEP_DIR_BIT] == EEP_DIR_READ);

  // Strobes
  assign bit_in    = active & scl_rise & (bit_cnt_q < EEP_BYTE_CNT);
  assign byte_end  = active & scl_fall & bits_done;
  assign slot_end  = active & scl_fall & ack_done;
  assign tx_step   = active & scl_fall & (phase_q == PH_RDATA) &
                     (bit_cnt_q != '0) & (bit_cnt_q < EEP_BYTE_CNT);
  assign load_rd   = slot_end & (phase_nx == PH_RDATA);
  assign accept    = slot_end & (phase_q == PH_SLAVE);
  assign wr_byte   = byte_end & (phase_q == PH_WDATA);

  // Address arithmetic
  assign addr_next = ADDR_W'(addr_q + 1'b1);
  assign page_idx  = addr_q[PAGE_W-1:0];
  assign page_next = {addr_q[ADDR_W-1:PAGE_W], PAGE_W'(page_idx + 1'b1)};
  assign rd_byte   = mem_q[addr_q];

  // Programming only starts at Stop, and never under protect
  assign write_go   = stop_det & (|page_vld_q) & ~wp_s & ~busy_q;
  assign busy_end   = busy_q & (busy_cnt_q == CNT_LAST);
  assign commit_idx = commit_q[PAGE_W-1:0];
  assign commit_en  = busy_q & ~commit_q[PAGE_W] & page_vld_q[commit_idx];

  always_comb begin
    case (phase_q)
      PH_SLAVE: phase_nx = dir_read ? PH_RDATA : PH_ADRH;
      PH_ADRH:  phase_nx = PH_ADRL;
      PH_ADRL:  phase_nx = PH_WDATA;
      PH_WDATA: phase_nx = PH_WDATA;
      PH_RDATA: phase_nx = m_ack_q ? PH_RDATA : PH_SKIP;
      default:  phase_nx = PH_SKIP;
    endcase
  end

  // Protocol state; SDA moves only after a clock fall
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      phase_q   <= PH_IDLE;
      bit_cnt_q <= '0;
      sda_oe_q  <= 1'b0;
      m_ack_q   <= 1'b0;
    end else if (start_det) begin
      phase_q   <= PH_SLAVE;
      bit_cnt_q <= '0;
      sda_oe_q  <= 1'b0;
    end else if (stop_det) begin
      phase_q   <= PH_IDLE;
      bit_cnt_q <= '0;
      sda_oe_q  <= 1'b0;
    end else if (active && scl_rise && !ack_done) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (bits_done) begin
        m_ack_q <= ~sda_s;
      end
    end else if (byte_end) begin
      if (phase_q == PH_RDATA) begin
        sda_oe_q <= 1'b0;
      end else if (phase_q == PH_SLAVE && !slave_hit) begin
        phase_q  <= PH_SKIP;
        sda_oe_q <= 1'b0;
      end else begin
        sda_oe_q <= 1'b1;
      end
    end else if (slot_end) begin
      bit_cnt_q <= '0;
      phase_q   <= phase_nx;
      sda_oe_q  <= (phase_nx == PH_RDATA) & ~rd_byte[EEP_BYTE_W-1];
    end else if (tx_step) begin
      sda_oe_q  <= ~tx_q[EEP_BYTE_W-2];
    end
  end

  // Receive shifter, transmit shifter and address pointer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      shift_q <= '0;
      tx_q    <= '0;
      addr_q  <= '0;
    end else begin
      if (bit_in) begin
        shift_q <= {shift_q[EEP_BYTE_W-2:0], sda_s};
      end
      if (load_rd) begin
        tx_q   <= rd_byte;
        addr_q <= addr_next;
      end else if (tx_step) begin
        tx_q <= {tx_q[EEP_BYTE_W-2:0], 1'b0};
      end else if (byte_end && phase_q == PH_ADRH) begin
        addr_q[ADDR_W-1:EEP_BYTE_W] <= shift_q[HI_W-1:0];
      end else if (byte_end && phase_q == PH_ADRL) begin
        addr_q[EEP_BYTE_W-1:0] <= shift_q;
      end else if (wr_byte) begin
        addr_q <= page_next;
      end
    end
  end

  // Page buffer; overflow simply overwrites earlier bytes
  always_ff @(posedge clk_in) begin
    if (wr_byte) begin
      page_buf_q[page_idx] <= shift_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      page_vld_q <= '0;
    end else if (busy_end || accept || (stop_det && !busy_q && !write_go)) begin
      page_vld_q <= '0;
    end else if (wr_byte) begin
      page_vld_q[page_idx] <= 1'b1;
    end
  end

  // Self-timed write; bytes trickle into the array while busy
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      busy_q     <= 1'b0;
      busy_cnt_q <= '0;
      commit_q   <= '0;
    end else if (write_go) begin
      busy_q     <= 1'b1;
      busy_cnt_q <= '0;
      commit_q   <= '0;
    end else if (busy_q) begin
      busy_cnt_q <= busy_cnt_q + 1'b1;
      if (busy_end) begin
        busy_q <= 1'b0;
      end
      if (!commit_q[PAGE_W]) begin
        commit_q <= commit_q + 1'b1;
      end
    end
  end

  // Array content is not reset, as in a real nonvolatile part
  always_ff @(posedge clk_in) begin
    if (commit_en) begin
      mem_q[{addr_q[ADDR_W-1:PAGE_W], commit_idx}] <= page_buf_q[commit_idx];
    end
  end

  // Open drain: only ever pulls low
  assign sda_out    = 1'b0;
  assign sda_oe_out = sda_oe_q;

  assign status_out.standby  = (phase_q == PH_IDLE) & ~busy_q;
  assign status_out.busy     = busy_q;
  assign status_out.selected = active & (phase_q != PH_SLAVE);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_hit_slot;
    byte_end && (phase_q == PH_SLAVE) && slave_hit;
  endsequence

  sequence s_miss_slot;
    byte_end && (phase_q == PH_SLAVE) && !slave_hit;
  endsequence

  property p_idle_quiet;
    (phase_q == PH_IDLE) |-> !sda_oe_q;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("SDA driven while idle");

  property p_start_slave;
    start_det |=> (phase_q == PH_SLAVE) && (bit_cnt_q == '0) && !sda_oe_q;
  endproperty
  a_start_slave: assert property (p_start_slave)
    else $error("Start did not reset protocol state");

  property p_stop_idle;
    stop_det |=> (phase_q == PH_IDLE) && !sda_oe_q;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("Stop did not end transaction");

  property p_hold_high;
    (scl_s && $past(scl_s) && !$past(start_det) && !$past(stop_det))
      |-> $stable(sda_oe_q);
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("SDA changed while SCL high");

  property p_shift;
    bit_in |=> (shift_q[0] == $past(sda_s));
  endproperty
  a_shift: assert property (p_shift)
    else $error("Bit not sampled on SCL rise");

  property p_slave_ack;
    s_hit_slot |=> sda_oe_q ##1 (sda_oe_q || scl_fall || stop_det || start_det);
  endproperty
  a_slave_ack: assert property (p_slave_ack)
    else $error("Matching address not acknowledged");

  property p_miss_skip;
    s_miss_slot |=> (phase_q == PH_SKIP) && !sda_oe_q;
  endproperty
  a_miss_skip: assert property (p_miss_skip)
    else $error("Foreign address not ignored");

  property p_busy_noack;
    busy_q && (phase_q == PH_SLAVE) |-> !sda_oe_q;
  endproperty
  a_busy_noack: assert property (p_busy_noack)
    else $error("Address acknowledged during write");

  property p_wp;
    $rose(busy_q) |-> $past(stop_det) && !$past(wp_s);
  endproperty
  a_wp: assert property (p_wp)
    else $error("Write started under protect");

  property p_write_bound;
    busy_q |-> (busy_cnt_q <= CNT_LAST);
  endproperty
  a_write_bound: assert property (p_write_bound)
    else $error("Write cycle overran");

  property p_page_wrap;
    wr_byte |=> (addr_q[ADDR_W-1:PAGE_W] == $past(addr_q[ADDR_W-1:PAGE_W])) &&
                (addr_q[PAGE_W-1:0] == PAGE_W'($past(addr_q[PAGE_W-1:0]) + 1'b1));
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("Page address did not wrap");

  property p_read_inc;
    load_rd |=> (addr_q == ADDR_W'($past(addr_q) + 1'b1)) && (tx_q == $past(rd_byte));
  endproperty
  a_read_inc: assert property (p_read_inc)
    else $error("Read pointer did not advance");

  property p_standby;
    $past(reset_in) |-> status_out.standby && !busy_q;
  endproperty
  a_standby: assert property (p_standby)
    else $error("Not in standby after reset");

endmodule

// ### hdl/eep_pkg.sv
package eep_pkg;

  localparam int         EEP_ADDR_W        = 13;
  localparam int         EEP_PAGE_W        = 5;
  localparam int         EEP_BYTE_W        = 8;
  localparam logic [3:0] EEP_TYPE_CODE     = 4'ha;
  localparam int         EEP_TYPE_MSB      = 7;
  localparam int         EEP_TYPE_LSB      = 4;
  localparam int         EEP_SEL_MSB       = 3;
  localparam int         EEP_SEL_LSB       = 1;
  localparam int         EEP_DIR_BIT       = 0;
  localparam logic       EEP_DIR_READ      = 1'b1;
  localparam logic [3:0] EEP_BYTE_CNT      = 4'h8;
  localparam logic [3:0] EEP_ACK_CNT       = 4'h9;
  localparam int         EEP_CLK_PERIOD_NS = 8;
  localparam int         EEP_WRITE_TIME_MS = 5;
  localparam int         EEP_NS_PER_MS     = 1000000;
  // Longest time, so the division rounds down
  localparam int         EEP_WRITE_CYCLES  =
    EEP_WRITE_TIME_MS * EEP_NS_PER_MS / EEP_CLK_PERIOD_NS;

  typedef struct packed {
    logic chip_select_strap_2;
    logic chip_select_strap_1;
    logic chip_select_strap_0;
  } eep_strap_type;

  typedef struct packed {
    logic          scl;
    logic          sda;
    logic          wp;
    eep_strap_type strap;
  } eep_pins_type;

  typedef struct packed {
    logic standby;
    logic busy;
    logic selected;
  } eep_status_type;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_SLAVE,
    PH_ADRH,
    PH_ADRL,
    PH_WDATA,
    PH_RDATA,
    PH_SKIP
  } eep_phase_type;

endpackage

// ### hdl/eep_sync2.sv
`timescale 1ns/10ps
module eep_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule

// ### verification/eep_master.sv
`timescale 1ns/10ps
module eep_master (
  input  wire logic       clk_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            sda_low_out,
  output logic            res_valid_out,
  output logic            res_kind_out,
  output logic [7:0]      res_data_out
);
  // Bus idles with clock high and data released
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    res_valid_out = 1'b0;
    res_kind_out = 1'b0;
    res_data_out = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Data moves mid-low so the slave sees setup and hold
  task automatic bit_io(input logic b, output logic r);
    tick(5);
    sda_low_out <= ~b;
    tick(5);
    scl_out <= 1'b1;
    tick(5);
    r = sda_in;
    tick(5);
    scl_out <= 1'b0;
  endtask

  task automatic bus_start();
    tick(5);
    sda_low_out <= 1'b0;
    tick(5);
    scl_out <= 1'b1;
    tick(5);
    sda_low_out <= 1'b1;
    tick(5);
    scl_out <= 1'b0;
  endtask

  task automatic bus_stop();
    tick(5);
    sda_low_out <= 1'b1;
    tick(5);
    scl_out <= 1'b1;
    tick(5);
    sda_low_out <= 1'b0;
    tick(5);
  endtask

  task automatic post(input logic k, input logic [7:0] d);
    res_kind_out <= k;
    res_data_out <= d;
    res_valid_out <= 1'b1;
    tick(1);
    res_valid_out <= 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    post(1'b0, {7'h00, ~r});
  endtask

  task automatic recv_byte(input logic ack);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, r);
    post(1'b1, d);
  endtask

  // Nine released clocks free a slave stuck mid-byte
  task automatic recover();
    logic r;
    repeat (9) bit_io(1'b1, r);
  endtask
endmodule

// ### verification/serial_eeprom_two_wire_slave_tb_top.sv
`timescale 1ns/10ps
module serial_eeprom_two_wire_slave_tb_top;
  import eep_pkg::*;
  // Short write time keeps the run small
  localparam int WR_CYC = 400;
  typedef struct packed {
    logic       kind;
    logic [7:0] val;
  } eep_note_type;
  logic           clk, reset, scl, sda_low, sda_oe, sda_drv, wp, res_valid, res_kind;
  logic [7:0]     res_data;
  logic           sda_wire;
  eep_strap_type  strap;
  eep_status_type status;
  eep_note_type   notes[$];
  eep_note_type   note;
  logic [7:0]     ref_mem [0:8191];
  logic [12:0]    ptr;
  logic [2:0]     rnd3;
  logic [4:0]     rnd5;
  logic           r;
  int             fail_count, check_count, seed;

  // Pull-up wins unless someone pulls low
  assign sda_wire = ~sda_low & (~sda_oe | sda_drv);

  eep_slave #(.WRITE_CYCLES(WR_CYC)) eep_slave_inst (.clk_in(clk), .reset_in(reset),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_drv), .sda_oe_out(sda_oe),
    .strap_in(strap), .wp_in(wp), .status_out(status));
  eep_master eep_master_inst (.clk_in(clk), .sda_in(sda_wire), .scl_out(scl),
    .sda_low_out(sda_low), .res_valid_out(res_valid), .res_kind_out(res_kind),
    .res_data_out(res_data));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic fail_line(input logic [7:0] e, input logic [7:0] g);
    fail_count++;
    $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
  endtask

  task automatic cmp_ack(input logic e, input logic g);
    check_count++;
    if (g !== e) fail_line({7'h00, e}, {7'h00, g});
  endtask

  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) fail_line(e, g);
  endtask

  task automatic cmp_status(input eep_status_type e, input eep_status_type g);
    check_count++;
    if (g !== e) fail_line({5'h00, e}, {5'h00, g});
  endtask

  always @(posedge clk) begin
    if (res_valid === 1'b1) begin
      if (notes.size() == 0) fail_line(8'hee, res_data);
      else begin
        note = notes.pop_front();
        if (note.kind !== res_kind) fail_line({7'h00, note.kind}, {7'h00, res_kind});
        else if (res_kind) cmp_byte(note.val, res_data);
        else cmp_ack(note.val[0], res_data[0]);
      end
    end
  end

  task automatic ack_ex(input logic [7:0] b, input logic e);
    notes.push_back({1'b0, 7'h00, e});
    eep_master_inst.send_byte(b);
  endtask

  task automatic rd_ex(input logic [7:0] e, input logic ack);
    notes.push_back({1'b1, e});
    eep_master_inst.recv_byte(ack);
  endtask

  function automatic logic [7:0] slv(input logic rw);
    return {4'ha, strap, rw};
  endfunction

  task automatic addr_seq(input logic [12:0] a);
    logic [2:0] junk;
    junk = 3'($random(seed));
    eep_master_inst.bus_start();
    ack_ex(slv(1'b0), 1'b1);
    ack_ex({junk, a[12:8]}, 1'b1);
    ack_ex(a[7:0], 1'b1);
  endtask

  task automatic do_write(input logic [12:0] a, input int n);
    logic [7:0] d;
    // Addressed and past the slave byte, so only selected is up
    addr_seq(a);
    cmp_status(3'h1, status);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      ack_ex(d, 1'b1);
      if (!wp) ref_mem[{a[12:5], a[4:0] + i[4:0]}] = d;
    end
    eep_master_inst.bus_stop();
  endtask

  // Poll while busy, then bound the self-timed write
  task automatic wait_done();
    int k;
    cmp_status(3'h2, status);
    eep_master_inst.bus_start();
    ack_ex(slv(1'b0), 1'b0);
    eep_master_inst.bus_stop();
    k = 0;
    while (status.busy !== 1'b0 && k < WR_CYC) begin
      tick(1);
      k++;
    end
    cmp_status(3'h4, status);
  endtask

  task automatic do_read(input logic [12:0] a, input int n);
    addr_seq(a);
    eep_master_inst.bus_start();
    ack_ex(slv(1'b1), 1'b1);
    for (int i = 0; i < n; i++) rd_ex(ref_mem[a + i[12:0]], i != n - 1);
    ptr = a + n[12:0];
    eep_master_inst.bus_stop();
  endtask

  task automatic cur_read();
    eep_master_inst.bus_start();
    ack_ex(slv(1'b1), 1'b1);
    rd_ex(ref_mem[ptr], 1'b0);
    ptr++;
    eep_master_inst.bus_stop();
  endtask

  task automatic wrap_up();
    if (notes.size() != 0) fail_count++;
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    tick(60000);
    fail_count++;
    wrap_up();
  end

  initial begin
    seed = 81516;
    reset = 1'b1;
    wp = 1'b0;
    strap = 3'h0;
    fail_count = 0;
    check_count = 0;
    tick(8);
    reset <= 1'b0;
    cmp_status(3'h4, status);
    tick(4);
    for (int k = 0; k < 8; k++) begin
      strap <= k[2:0];
      rnd3 = 3'(({$random(seed)} % 7) + 1);
      rnd5 = 5'(({$random(seed)} % 15) + 1);
      tick(2);
      eep_master_inst.bus_start();
      ack_ex({4'ha, k[2:0], 1'b0}, 1'b1);
      eep_master_inst.bus_start();
      ack_ex({4'ha, k[2:0] ^ rnd3, 1'b0}, 1'b0);
      eep_master_inst.bus_start();
      ack_ex({4'ha ^ rnd5[3:0], k[2:0], 1'b0}, 1'b0);
      eep_master_inst.bus_stop();
    end
    rnd3 = 3'($random(seed));
    rnd5 = 5'($random(seed));
    strap <= rnd3;
    tick(2);
    do_write(13'h0000, 3);
    wait_done();
    do_write({8'hff, rnd5}, 33);
    wait_done();
    do_read(13'h1fe0, 32);
    do_read(13'h1fff, 3);
    cur_read();
    eep_master_inst.bus_start();
    for (int i = 0; i < 4; i++) eep_master_inst.bit_io(i[0], r);
    eep_master_inst.recover();
    do_read(13'h1fe7, 1);
    wp <= 1'b1;
    tick(2);
    do_write(13'h0001, 2);
    cmp_status(3'h4, status);
    wp <= 1'b0;
    do_read(13'h0001, 2);
    reset <= 1'b1;
    tick(8);
    cmp_status(3'h4, status);
    reset <= 1'b0;
    tick(4);
    ptr = 13'h0000;
    cur_read();
    wrap_up();
  end
endmodule
